// ===== verilog/nhs_port.sv
// serial host port with mode decoder, response memory and host clock output
`timescale 1ns/1ps
module nhs_port
  import nhs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // interface strap
  input wire logic i2c_strap,
  output logic i2c_mode,
  // serial pins
  input wire logic sclk,
  input wire logic slave_select_n,
  input wire logic mosi,
  output logic sdo,
  output logic sdo_oe,
  output logic sdo_pulldown,
  // core status
  input wire logic osc_en,
  input wire logic xtal_stable,
  input wire logic xtal_running,
  // clocks for the host clock output
  input wire logic lf_clk,
  input wire logic xtal_clk,
  output logic mcu_clk,
  // register file of the core
  output logic reg_wr,
  output logic [5:0] reg_waddr,
  output logic [7:0] reg_wdata,
  output logic reg_space_b,
  output logic [5:0] reg_raddr,
  input wire logic [7:0] reg_rdata,
  // transmit and receive buffer
  output logic fifo_wr,
  output logic [7:0] fifo_wdata,
  output logic fifo_rd,
  input wire logic [7:0] fifo_rdata,
  // direct commands
  output logic cmd_valid,
  output logic [5:0] cmd_code,
  // response memory read port for the core
  input wire logic [5:0] pt_raddr,
  output logic [7:0] pt_rdata
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  nhs_state_t st, next_st;
  logic sclk_q, xtal_q, strap_done, next_i2c;
  logic [2:0] cnt, next_cnt, dcnt, next_dcnt;
  logic [7:0] rx, next_rx, tx, next_tx, cfg1, next_cfg1, cfg2, next_cfg2;
  logic [5:0] addr, next_addr, pti, next_pti, next_cmd, next_waddr;
  logic [7:0] next_wdata, next_fwdata;
  logic next_sdo, next_oe, spb, next_spb, pend, next_pend, next_cmd_v;
  logic next_wr, next_frd, next_fwr, next_mcu, pt_we;
  logic [7:0] target_response_memory [PT_DEPTH];
  logic fall, rise, sel_n, bit_end, acc_ok, rd_active;
  logic [7:0] rx_byte, rd_val, pt_val;

  // edges of the sampled serial clock; pins are synchronous to clk
  assign fall = sclk_q & ~sclk;
  assign rise = ~sclk_q & sclk;
  // port stays deselected until the strap says serial peripheral mode
  assign sel_n = slave_select_n | ~strap_done | i2c_mode;
  assign bit_end = ~sel_n & fall & (cnt == BIT_LAST);
  assign rx_byte = {rx[6:0], mosi};
  assign acc_ok = osc_en & xtal_stable;
  assign rd_active = (st == ST_RREG) | (st == ST_FRD) | (st == ST_PTRD);
  assign reg_raddr = (st == ST_MODE) ? rx_byte[5:0] : addr;
  assign reg_space_b = spb;
  assign sdo_pulldown = ~sdo_oe & (cfg2[PDA_BIT] | cfg2[PDB_BIT]);

  // read value: local config registers answer in space A, else the core
  always_comb begin
    rd_val = reg_rdata;
    if (!spb && reg_raddr == CFG1_ADDR) rd_val = cfg1;
    else if (!spb && reg_raddr == CFG2_ADDR) rd_val = cfg2;
  end
  // memory reads past the last location return zero
  assign pt_val = (pti <= PT_LAST) ? target_response_memory[pti] : 8'h00;

  // ----------------------------------------------------------------
  // serial decoder
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_rx = rx;
    next_tx = tx;
    next_addr = addr;
    next_pti = pti;
    next_spb = spb;
    next_pend = pend;
    next_sdo = sdo;
    next_oe = sdo_oe;
    next_cmd = cmd_code;
    next_cmd_v = 1'b0;
    next_wr = 1'b0;
    next_waddr = reg_waddr;
    next_wdata = reg_wdata;
    next_fwr = 1'b0;
    next_fwdata = fifo_wdata;
    next_frd = 1'b0;
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    pt_we = 1'b0;
    // a pending command goes out at release, or at the first fall of a chained byte
    if (pend && (sel_n || fall)) begin
      next_cmd_v = 1'b1;
      next_pend = 1'b0;
    end
    if (sel_n) begin
      // release ends the frame, drops any partial byte
      next_st = ST_MODE;
      next_cnt = 3'h0;
      next_spb = 1'b0;
      next_oe = 1'b0;
    end else begin
      if (fall) begin
        next_rx = rx_byte;
        next_cnt = 3'(cnt + 3'h1);
      end
      if (bit_end) begin
        case (st)
          ST_MODE: begin
            if (rx_byte == PREFIX_B && !spb) next_spb = 1'b1;
            else begin
              case (rx_byte[7:6])
                MODE_WREG: begin
                  next_st = ST_WREG;
                  next_addr = rx_byte[5:0];
                end
                MODE_RREG: begin
                  next_st = ST_RREG;
                  next_tx = rd_val;
                  next_addr = 6'(rx_byte[5:0] + 6'h01);
                end
                MODE_SPEC: begin
                  next_st = ST_SKIP;
                  if (acc_ok) begin
                    case (rx_byte[5:0])
                      TR_FIFO_LD: next_st = ST_FLD;
                      TR_FIFO_RD: begin
                        next_st = ST_FRD;
                        next_tx = fifo_rdata;
                        next_frd = 1'b1;
                      end
                      TR_PT_A, TR_PT_F, TR_PT_SLOT: begin
                        next_st = ST_PTLD;
                        next_pti = (rx_byte[5:0] == TR_PT_A) ? PT_START_A :
                            (rx_byte[5:0] == TR_PT_F) ? PT_START_F : PT_START_SLOT;
                      end
                      TR_PT_RD: begin
                        next_st = ST_PTRD;
                        next_tx = target_response_memory[0];
                        next_pti = 6'h01;
                      end
                      default: next_st = ST_SKIP;
                    endcase
                  end
                end
                default: begin
                  next_cmd = rx_byte[5:0];
                  next_pend = 1'b1;
                end
              endcase
            end
          end
          ST_WREG: begin
            next_wr = 1'b1;
            next_waddr = addr;
            next_wdata = rx_byte;
            next_addr = 6'(addr + 6'h01);
            // only existing local registers take the value
            if (!spb && addr == CFG1_ADDR) next_cfg1 = rx_byte;
            else if (!spb && addr == CFG2_ADDR) next_cfg2 = rx_byte;
          end
          ST_RREG: begin
            next_tx = rd_val;
            next_addr = 6'(addr + 6'h01);
          end
          ST_FLD: begin
            next_fwr = 1'b1;
            next_fwdata = rx_byte;
          end
          ST_FRD: begin
            next_tx = fifo_rdata;
            next_frd = 1'b1;
          end
          ST_PTLD: begin
            pt_we = (pti <= PT_LAST);
            next_pti = (pti <= PT_LAST) ? 6'(pti + 6'h01) : pti;
          end
          ST_PTRD: begin
            next_tx = pt_val;
            next_pti = (pti <= PT_LAST) ? 6'(pti + 6'h01) : pti;
          end
          default: next_st = ST_SKIP;
        endcase
      end
      if (rise) begin
        // shift out on the rising edge so the master samples a settled bit
        next_sdo = tx[7];
        next_tx = {tx[6:0], 1'b0};
        next_oe = rd_active;
      end
    end
  end

  // decoder registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= ST_MODE;
      sclk_q <= 1'b0;
      cnt <= 3'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      addr <= 6'h00;
      pti <= 6'h00;
      spb <= 1'b0;
      pend <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      cmd_code <= 6'h00;
      cmd_valid <= 1'b0;
      reg_wr <= 1'b0;
      reg_waddr <= 6'h00;
      reg_wdata <= 8'h00;
      fifo_wr <= 1'b0;
      fifo_wdata <= 8'h00;
      fifo_rd <= 1'b0;
      cfg1 <= CFG1_RST;
      cfg2 <= CFG2_RST;
    end else begin
      st <= next_st;
      sclk_q <= sclk;
      cnt <= next_cnt;
      rx <= next_rx;
      tx <= next_tx;
      addr <= next_addr;
      pti <= next_pti;
      spb <= next_spb;
      pend <= next_pend;
      sdo <= next_sdo;
      sdo_oe <= next_oe;
      cmd_code <= next_cmd;
      cmd_valid <= next_cmd_v;
      reg_wr <= next_wr;
      reg_waddr <= next_waddr;
      reg_wdata <= next_wdata;
      fifo_wr <= next_fwr;
      fifo_wdata <= next_fwdata;
      fifo_rd <= next_frd;
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
    end
  end

  // response memory: serial writes, registered core read port
  always_ff @(posedge clk) begin
    if (pt_we) begin
      target_response_memory[pti] <= rx_byte;
    end
    pt_rdata <= (pt_raddr <= PT_LAST) ? target_response_memory[pt_raddr] : 8'h00;
  end

  // ----------------------------------------------------------------
  // strap capture and host clock output
  // ----------------------------------------------------------------
  always_comb begin
    next_i2c = strap_done ? i2c_mode : i2c_strap;
    next_dcnt = (xtal_clk & ~xtal_q) ? 3'(dcnt + 3'h1) : dcnt;
    // divider bits give 13.56, 6.78 and 3.39 MHz from the crystal
    next_mcu = 1'b0;
    if (!xtal_running) begin
      next_mcu = lf_clk & ~cfg1[LFOFF_BIT];
    end else begin
      case (cfg1[OUTC_LSB +: 2])
        OC_13M56: next_mcu = dcnt[0];
        OC_6M78: next_mcu = dcnt[1];
        OC_3M39: next_mcu = dcnt[2];
        default: next_mcu = 1'b0;
      endcase
    end
  end

  // strap is caught on the first edge after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_done <= 1'b0;
      i2c_mode <= 1'b0;
      xtal_q <= 1'b0;
      dcnt <= 3'h0;
      mcu_clk <= 1'b0;
    end else begin
      strap_done <= 1'b1;
      i2c_mode <= next_i2c;
      xtal_q <= xtal_clk;
      dcnt <= next_dcnt;
      mcu_clk <= next_mcu;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_byte;
    (st == ST_WREG) && bit_end;
  endsequence
  chk_release_idle: assert property (sel_n |=> !sdo_oe && st == ST_MODE)
    else $error("port not idle after select release");
  chk_pulldown_on: assert property (!sdo_oe && cfg2[PDA_BIT] |-> sdo_pulldown)
    else $error("pull-down missing while released");
  chk_write_commit: assert property (s_wr_byte
      |=> reg_wr && reg_wdata == $past(rx_byte))
    else $error("register byte not committed");
  chk_addr_step: assert property (s_wr_byte |=> addr == 6'($past(addr) + 6'h01))
    else $error("address did not advance by one");
  chk_cmd_launch: assert property (pend && sel_n |=> cmd_valid ##1 !cmd_valid)
    else $error("command not launched once at release");
  chk_access_gate: assert property ((st == ST_MODE) && bit_end && !spb && !acc_ok
      && rx_byte[7:6] == MODE_SPEC |=> st == ST_SKIP)
    else $error("buffer access taken without enable");
  chk_lf_clock: assert property (!xtal_running && !cfg1[LFOFF_BIT]
      |=> mcu_clk == $past(lf_clk))
    else $error("low-frequency clock not on host clock");
  chk_clk_off: assert property ((xtal_running && cfg1[OUTC_LSB +: 2] == OC_OFF) [*2]
      |=> !mcu_clk)
    else $error("host clock not stopped");
  chk_space_b: assert property ((st == ST_MODE) && bit_end && rx_byte == PREFIX_B
      && !spb |=> spb)
    else $error("second space not selected");
  chk_sdo_shift: assert property (!sel_n && rise && rd_active
      |=> sdo == $past(tx[7]) && sdo_oe)
    else $error("data out not updated on rising edge");
endmodule // nhs_port

// ===== shared/nhs_pkg.sv
// constants and types for the nfc host serial port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package nhs_pkg;
  // operation mode field of the first byte
  localparam logic [1:0] MODE_WREG = 2'h0;
  localparam logic [1:0] MODE_RREG = 2'h1;
  localparam logic [1:0] MODE_SPEC = 2'h2;
  localparam logic [1:0] MODE_CMD = 2'h3;
  // trailers of the special mode
  localparam logic [5:0] TR_FIFO_LD = 6'h00;
  localparam logic [5:0] TR_FIFO_RD = 6'h1F;
  localparam logic [5:0] TR_PT_A = 6'h20;
  localparam logic [5:0] TR_PT_F = 6'h28;
  localparam logic [5:0] TR_PT_SLOT = 6'h2C;
  localparam logic [5:0] TR_PT_RD = 6'h3F;
  localparam logic [7:0] PREFIX_B = 8'hFB;
  // response memory start locations and size
  localparam logic [5:0] PT_START_A = 6'h00;
  localparam logic [5:0] PT_START_F = 6'h0F;
  localparam logic [5:0] PT_START_SLOT = 6'h24;
  localparam logic [5:0] PT_LAST = 6'h2F;
  localparam int PT_DEPTH = 48;
  // io configuration registers held locally
  localparam logic [5:0] CFG1_ADDR = 6'h01;
  localparam logic [5:0] CFG2_ADDR = 6'h02;
  localparam int OUTC_LSB = 0;
  localparam int LFOFF_BIT = 2;
  localparam int PDA_BIT = 0;
  localparam int PDB_BIT = 1;
  localparam logic [7:0] CFG1_RST = 8'h01;
  localparam logic [7:0] CFG2_RST = 8'h00;
  // clock output select codes
  localparam logic [1:0] OC_OFF = 2'h0;
  localparam logic [1:0] OC_3M39 = 2'h1;
  localparam logic [1:0] OC_6M78 = 2'h2;
  localparam logic [1:0] OC_13M56 = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    ST_MODE, ST_WREG, ST_RREG, ST_FLD, ST_FRD, ST_PTLD, ST_PTRD, ST_SKIP
  } nhs_state_t;
endpackage

// ===== testbench/nhs_mcu_model.sv
// spi master model standing in for the host microcontroller
`timescale 1ns/1ps
module nhs_mcu_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic sclk,
  output logic slave_select_n,
  output logic mosi,
  input wire logic sdo_pin
);
  // idle: select high, serial clock low for polarity 0
  initial begin
    sclk = 1'b0;
    slave_select_n = 1'b1;
    mosi = 1'b0;
  end

  // half a serial clock period; four system clocks keep each phase above two
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // every transfer opens with select pulled low; only short commands are
  // issued, so no completion wait is modelled
  task automatic select();
    half();
    slave_select_n = 1'b0;
    half();
  endtask

  // released mosi shows the inverse of its last value, never a stale copy
  task automatic release_sel();
    half();
    slave_select_n = 1'b1;
    mosi = ~mosi;
    half();
  endtask

  // one byte, msb first: data changes on the rise, both sides sample on the fall
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      mosi = tx[i];
      half();
      sclk = 1'b0;
      rx[i] = sdo_pin;
      half();
    end
  endtask

  // a few clock pulses without a whole byte, for the abort case
  task automatic bits(input int n);
    repeat (n) begin
      sclk = 1'b1;
      half();
      sclk = 1'b0;
      half();
    end
  endtask
endmodule // nhs_mcu_model

// ===== testbench/testbench.sv
// self-checking bench for the nfc host serial port
`timescale 1ns/1ps
module testbench;
  import nhs_pkg::*;
  // ----------------------------------------------------------------
  // signals and core stand-ins
  // ----------------------------------------------------------------
  logic clk, rst, i2c_strap, i2c_mode, sclk, slave_select_n, mosi, sdo, sdo_oe, sdo_pulldown;
  logic osc_en, xtal_stable, xtal_running, lf_clk, xtal_clk, mcu_clk;
  logic reg_wr, reg_space_b, fifo_wr, fifo_rd, cmd_valid;
  logic [5:0] reg_waddr, reg_raddr, cmd_code, pt_raddr;
  logic [7:0] reg_wdata, reg_rdata, fifo_wdata, fifo_rdata, pt_rdata, head;
  logic [2:0] div;
  logic [13:0] wq[$];
  logic [7:0] fq[$];
  logic [5:0] cq[$];
  logic [7:0] rx[$];
  logic [7:0] tmp;
  logic space_seen;
  int num_errors = 0;
  int checked = 0;
  // pin level: driven, else pulled down, else floating
  wire sdo_pin = sdo_oe ? sdo : (sdo_pulldown ? 1'b0 : 1'bz);
  // core registers live from 10h up; lower addresses are empty and read zero
  assign reg_rdata = (reg_raddr >= 6'h10) ? {2'h2, reg_raddr} : 8'h00;
  assign fifo_rdata = head;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  nhs_port u_dut (.clk(clk), .rst(rst), .i2c_strap(i2c_strap), .i2c_mode(i2c_mode),
    .sclk(sclk), .slave_select_n(slave_select_n), .mosi(mosi), .sdo(sdo), .sdo_oe(sdo_oe),
    .sdo_pulldown(sdo_pulldown), .osc_en(osc_en), .xtal_stable(xtal_stable),
    .xtal_running(xtal_running), .lf_clk(lf_clk), .xtal_clk(xtal_clk), .mcu_clk(mcu_clk),
    .reg_wr(reg_wr), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
    .reg_space_b(reg_space_b), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
    .fifo_wr(fifo_wr), .fifo_wdata(fifo_wdata), .fifo_rd(fifo_rd), .fifo_rdata(fifo_rdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .pt_raddr(pt_raddr), .pt_rdata(pt_rdata));

  nhs_mcu_model u_mcu (.clk(clk), .sclk(sclk), .slave_select_n(slave_select_n),
    .mosi(mosi), .sdo_pin(sdo_pin));

  // ----------------------------------------------------------------
  // monitors and clock sources
  // ----------------------------------------------------------------
  // crystal toggles every clk; low-frequency clock is scaled to 16 clk per period
  always @(posedge clk) begin
    #1;
    xtal_clk = ~xtal_clk;
    div = div + 3'h1;
    if (div == 3'h0) lf_clk = ~lf_clk;
  end
  // record every pulse the core would see; the buffer head advances on each pop
  // sampled just after the edge, once the registered pulses have settled
  always @(posedge clk) begin
    #1;
    if (reg_wr === 1'b1) wq.push_back({reg_waddr, reg_wdata});
    if (reg_wr === 1'b1 && reg_space_b === 1'b1) space_seen = 1'b1;
    if (fifo_wr === 1'b1) fq.push_back(fifo_wdata);
    if (cmd_valid === 1'b1) cq.push_back(cmd_code);
    if (fifo_rd === 1'b1) head <= head + 8'h01;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one framed transfer of whole bytes, answers collected in order
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] got[$]);
    got.delete();
    u_mcu.select();
    foreach (tx[i]) begin
      u_mcu.xbyte(tx[i], tmp);
      got.push_back(tmp);
    end
    u_mcu.release_sel();
  endtask

  task automatic expect_w(input logic [13:0] e);
    check(wq.size() > 0 ? {2'h0, wq.pop_front()} : 16'hDEAD, {2'h0, e});
  endtask

  // counts host clock rises over 128 clk; one edge of slack for the window ends
  task automatic count_clk(input int exp);
    int n;
    logic prev;
    n = 0;
    prev = mcu_clk;
    repeat (128) begin
      @(posedge clk);
      #1;
      if (mcu_clk === 1'b1 && prev === 1'b0) n++;
      prev = mcu_clk;
    end
    check({15'h0, (n + 1 >= exp) && (n <= exp + 1)}, 16'h0001);
  endtask

  task automatic pt_peek(input logic [5:0] a, input logic [7:0] e);
    pt_raddr = a;
    repeat (2) @(posedge clk);
    #1;
    check({8'h0, pt_rdata}, {8'h0, e});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] pat[3];
    logic [5:0] st[3];
    logic [7:0] d;
    rst = 1'b1;
    i2c_strap = 1'b0;
    osc_en = 1'b0;
    xtal_stable = 1'b1;
    xtal_running = 1'b0;
    pt_raddr = 6'h00;
    xtal_clk = 1'b0;
    lf_clk = 1'b0;
    div = 3'h0;
    head = 8'h40;
    space_seen = 1'b0;
    pat = '{8'hA0, 8'hA8, 8'hAC};
    st = '{6'h00, 6'h0F, 6'h24};
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({15'h0, i2c_mode}, 16'h0000);
    check({14'h0, sdo_oe, sdo_pulldown}, 16'h0000);
    // defaults, then an empty address reads zero
    xfer({8'h41, 8'h00, 8'h00, 8'h00}, rx);
    check({8'h0, rx[1]}, 16'h0001);
    check({8'h0, rx[2]}, 16'h0000);
    check({8'h0, rx[3]}, 16'h0000);
    check({15'h0, sdo_oe}, 16'h0000);
    // burst write and burst read with address increment
    wq.delete();
    xfer({8'h05, 8'hA5, 8'h3C}, rx);
    expect_w({6'h05, 8'hA5});
    expect_w({6'h06, 8'h3C});
    xfer({8'h5E, 8'h00, 8'h00}, rx);
    check({rx[1], rx[2]}, 16'h9E9F);
    // pull-down only when released and an option bit is set
    for (int v = 0; v < 4; v++) begin
      xfer({8'h02, 8'(v)}, rx);
      check({15'h0, sdo_pulldown}, {15'h0, v != 0});
    end
    // space b writes to 01h/02h must leave the local config registers alone
    xfer({8'hFB, 8'h01, 8'hFF, 8'hFF}, rx);
    xfer({8'h41, 8'h00, 8'h00}, rx);
    check({rx[1], rx[2]}, 16'h0103);
    // second space lasts only until select rises
    wq.delete();
    space_seen = 1'b0;
    xfer({8'hFB, 8'h07, 8'h11}, rx);
    check({15'h0, space_seen}, 16'h0001);
    check({15'h0, reg_space_b}, 16'h0000);
    expect_w({6'h07, 8'h11});
    // aborted partial byte must not shift the next transfer
    u_mcu.select();
    u_mcu.bits(3);
    u_mcu.release_sel();
    xfer({8'h09, 8'h5A}, rx);
    expect_w({6'h09, 8'h5A});
    // buffer refused without enable, accepted with it
    xfer({8'h80, 8'h12}, rx);
    check(16'(fq.size()), 16'h0000);
    osc_en = 1'b1;
    xfer({8'h80, 8'h12, 8'h34}, rx);
    check(fq.size() == 2 ? {fq[0], fq[1]} : 16'hDEAD, 16'h1234);
    xfer({8'h9F, 8'h00, 8'h00}, rx);
    check({rx[1], rx[2]}, 16'h4041);
    // all three response memory load entries, then read-back from location 0
    for (int i = 0; i < 3; i++) begin
      d = 8'hC0 + 8'(i * 16);
      xfer({pat[i], d, d + 8'h01}, rx);
      pt_peek(st[i], d);
      pt_peek(st[i] + 6'h01, d + 8'h01);
    end
    xfer({8'hBF, 8'h00, 8'h00}, rx);
    check({rx[1], rx[2]}, 16'hC0C1);
    // command runs only after select rises; a chained one then a write
    u_mcu.select();
    u_mcu.xbyte(8'hC3, tmp);
    check(16'(cq.size()), 16'h0000);
    u_mcu.release_sel();
    check(cq.size() > 0 ? {10'h0, cq.pop_front()} : 16'hDEAD, 16'h0003);
    wq.delete();
    xfer({8'hC5, 8'h0A, 8'h66}, rx);
    check(cq.size() > 0 ? {10'h0, cq.pop_front()} : 16'hDEAD, 16'h0005);
    expect_w({6'h0A, 8'h66});
    // host clock: low-frequency source, its off bit, then the crystal divisions
    count_clk(8);
    xfer({8'h01, 8'h05}, rx);
    count_clk(0);
    xtal_running = 1'b1;
    for (int c = 0; c < 4; c++) begin
      xfer({8'h01, 8'(c)}, rx);
      count_clk(c == 0 ? 0 : 4 << c);
    end
    // two-wire strap shuts the serial port out
    i2c_strap = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({15'h0, i2c_mode}, 16'h0001);
    wq.delete();
    xfer({8'h05, 8'h77}, rx);
    check(16'(wq.size()), 16'h0000);
    report_and_stop();
  end

  // watchdog sized well above the roughly 60 us the sequence needs
  initial begin
    #300000;
    num_errors++;
    report_and_stop();
  end
endmodule // testbench
